// file: mpsl_pkg.sv
// Constants and carrier types for the MII pin strap and LED block
package mpsl_pkg;

  // Clock and derived pin clock rates
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned RXC_FAST_HZ   = 25_000_000;
  localparam int unsigned RXC_SLOW_HZ   = 2_500_000;
  localparam int unsigned RXC_FAST_CYC  = CLK_HZ / RXC_FAST_HZ;
  localparam int unsigned RXC_SLOW_CYC  = CLK_HZ / RXC_SLOW_HZ;

  // Reference clock input in RMII mode, nominal rate
  localparam int unsigned REF_CLK_HZ    = 50_000_000;
  // Cycles without a reference edge before it is reported lost
  localparam int unsigned REF_LOSS_CYC  = 32;
  // Activity blink half period, 100 ms
  localparam int unsigned LED_BLINK_NS  = 100_000_000;
  localparam int unsigned LED_BLINK_CYC = LED_BLINK_NS / (1_000_000_000 / CLK_HZ);

  // Register bus
  localparam int unsigned AW = 5;
  localparam int unsigned DW = 16;

  localparam logic [AW-1:0] REG_CTRL    = 5'h00;
  localparam logic [AW-1:0] REG_STRAP   = 5'h10;
  localparam logic [AW-1:0] REG_IRQ_STS = 5'h11;
  localparam logic [AW-1:0] REG_IRQ_MSK = 5'h12;
  localparam logic [AW-1:0] REG_VEND    = 5'h1F;

  localparam int unsigned CTRL_ISO_BIT    = 10;
  localparam int unsigned CTRL_SPEED_BIT  = 13;
  localparam int unsigned CTRL_LOOP_BIT   = 14;
  localparam int unsigned VEND_INTPOL_BIT = 9;

  // Interrupt status and mask layout
  localparam int unsigned IRQ_LINK    = 0;
  localparam int unsigned IRQ_RXERR   = 1;
  localparam int unsigned IRQ_COL     = 2;
  localparam int unsigned IRQ_REFLOSS = 3;
  localparam int unsigned IRQ_W       = 4;

  localparam logic             INTPOL_RST  = 1'h0;
  localparam logic [IRQ_W-1:0] IRQ_MSK_RST = 4'h0;

  typedef struct packed {
    logic test_mode;
    logic phy_address_bit0_strap;
    logic speed100;
    logic reduced_back_to_back_strap;
    logic rmii;
    logic isolate;
    logic coding_loopback_strap;
  } mpsl_cfg_t;

  // Shared pin levels read back from the pads
  typedef struct packed {
    logic reference_clock_in;
    logic link_activity_led;
    logic intr;
    logic crs;
    logic col;
    logic rxer;
    logic rxdv;
  } mpsl_pin_in_t;

  typedef struct packed {
    logic [3:0] rxd;
    logic       rxdv;
    logic       rxc;
    logic       rxer;
    logic       col;
    logic       crs;
    logic       intr;
    logic       link_activity_led;
    logic       txc;
  } mpsl_pad_t;

  typedef struct packed {
    logic       valid;
    logic       err;
    logic [3:0] data;
  } mpsl_rx_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          we;
    logic          re;
  } mpsl_req_t;

endpackage

// file: mpsl_sync.sv
// Two flip-flop synchroniser for pad levels
`timescale 1ns/10ps
module mpsl_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             mclk_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } mpsl_sync_st_t;

  mpsl_sync_st_t q;
  mpsl_sync_st_t d;

  // No reset: straps must be sampled while reset is held
  always_comb
  begin
    d    = q;
    d.s1 = async_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge mclk_i)
  begin
    q <= d;
  end

  assign sync_o = q.s2;

endmodule // mpsl_sync

// file: mpsl_div.sv
// Divider giving a period tick and a half-period level, two selectable periods
`timescale 1ns/10ps
module mpsl_div #(
  parameter int unsigned FAST = 5,
  parameter int unsigned SLOW = 50
) (
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  input  wire logic sel_fast_i,
  output logic      tick_o,
  output logic      level_o
);

  localparam int unsigned CW = $clog2(((FAST > SLOW) ? FAST : SLOW) + 1);
  localparam logic [CW-1:0] FAST_LAST = CW'(FAST - 1);
  localparam logic [CW-1:0] SLOW_LAST = CW'(SLOW - 1);
  localparam logic [CW-1:0] FAST_HALF = CW'(FAST / 2);
  localparam logic [CW-1:0] SLOW_HALF = CW'(SLOW / 2);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          sel;
    logic          tick;
    logic          level;
  } mpsl_div_st_t;

  mpsl_div_st_t q;
  mpsl_div_st_t d;

  always_comb
  begin
    d      = q;
    d.sel  = sel_fast_i;
    d.tick = 1'h0;
    // A change of rate restarts the period so no short glitch period appears later
    if (sel_fast_i != q.sel || q.cnt == (q.sel ? FAST_LAST : SLOW_LAST))
    begin
      d.cnt  = '0;
      d.tick = 1'h1;
    end
    else
    begin
      d.cnt = q.cnt + CW'(1);
    end
    d.level = d.cnt < (sel_fast_i ? FAST_HALF : SLOW_HALF);
    if (!rstn_i)
    begin
      d     = '0;
      // Parked on the last count so the first period after reset is a full one
      d.cnt = SLOW_LAST;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    q <= d;
  end

  assign tick_o  = q.tick;
  assign level_o = q.level;

endmodule // mpsl_div

// file: mpsl_top.sv
// MII shared pins: strap capture at reset, clock, data, interrupt and LED drive
`timescale 1ns/10ps
// Operation
// RULE1 - The receive clock pin runs at 25 MHz at 100 Mbps and at 2.5 MHz at 10 Mbps.
// RULE2 - The level on the data valid pin during reset becomes the coding loopback enable.
// RULE3 - The level on the receive error pin during reset becomes the isolate setting.
// RULE4 - The level on the collision pin during reset picks reduced or full MII.
// RULE5 - With reduced MII picked, the carrier sense pin level becomes back-to-back mode.
// RULE6 - The interrupt pin is driven with an active level set by bit 9 of register 1f.
// RULE7 - The level on the interrupt pin during reset becomes bit 0 of the PHY address.
// RULE8 - The level on the LED pin during reset becomes speed select, bit 13 of register 0.
// RULE9 - The transmit clock pin drives the clock, but takes a 50 MHz reference in RMII mode.
// RULE10 - A pull-down on the LED pin during reset means factory test, so boards avoid it.
// RULE11 - Receive data carry a nibble only while data valid is high.
// RULE12 - The LED is high with no link, low with link, and toggles on activity.
// RULE13 - Straps are held from the release of reset and the pins then turn to outputs.
module mpsl_top #(
  parameter int unsigned BLINK_CYC = mpsl_pkg::LED_BLINK_CYC
) (
  input  wire logic                    mclk_i,
  input  wire logic                    rstn_i,
  input  wire mpsl_pkg::mpsl_pin_in_t  pin_i,
  output mpsl_pkg::mpsl_pad_t          pad_o,
  output mpsl_pkg::mpsl_pad_t          pad_oe_o,
  input  wire mpsl_pkg::mpsl_rx_t      rx_i,
  input  wire logic                    col_i,
  input  wire logic                    crs_i,
  input  wire logic                    link_up_i,
  input  wire logic                    activity_i,
  input  wire mpsl_pkg::mpsl_req_t     req_i,
  output logic [mpsl_pkg::DW-1:0]      rdata_o,
  output mpsl_pkg::mpsl_cfg_t          cfg_o,
  output logic                         irq_o
);

  typedef struct packed {
    mpsl_pkg::mpsl_cfg_t       strap;
    mpsl_pkg::mpsl_cfg_t       cfg;
    logic                      intpol;
    logic [mpsl_pkg::IRQ_W-1:0] sts;
    logic [mpsl_pkg::IRQ_W-1:0] msk;
    logic [mpsl_pkg::DW-1:0]   rdata;
    mpsl_pkg::mpsl_pad_t       pad;
    mpsl_pkg::mpsl_pad_t       oe;
    logic                      link_prev;
    logic                      ref_prev;
    logic [5:0]                ref_cnt;
    logic                      ref_alive;
    logic                      irq;
  } mpsl_st_t;

  localparam logic [5:0] REF_LOSS = 6'(mpsl_pkg::REF_LOSS_CYC);

  mpsl_st_t              q;
  mpsl_st_t              d;
  mpsl_pkg::mpsl_pin_in_t pin_s;
  logic                  clk_tick;
  logic                  clk_level;
  logic                  blink_tick;
  logic [mpsl_pkg::IRQ_W-1:0] ev;
  logic [mpsl_pkg::IRQ_W-1:0] w1c;

  mpsl_sync #(
    .WIDTH ($bits(mpsl_pkg::mpsl_pin_in_t))
  ) u_sync (
    .mclk_i  (mclk_i),
    .async_i (pin_i),
    .sync_o  (pin_s)
  );

  // Pin clock divider, one period per nibble
  mpsl_div #(
    .FAST (mpsl_pkg::RXC_FAST_CYC),
    .SLOW (mpsl_pkg::RXC_SLOW_CYC)
  ) u_clkdiv (
    .mclk_i     (mclk_i),
    .rstn_i     (rstn_i),
    .sel_fast_i (q.cfg.speed100),
    .tick_o     (clk_tick),
    .level_o    (clk_level)
  );

  mpsl_div #(
    .FAST (BLINK_CYC),
    .SLOW (BLINK_CYC)
  ) u_blink (
    .mclk_i     (mclk_i),
    .rstn_i     (rstn_i),
    .sel_fast_i (1'h1),
    .tick_o     (blink_tick),
    .level_o    ()
  );

  always_comb
  begin
    d       = q;
    d.rdata = '0;
    ev      = '0;
    w1c     = '0;

    // Pin clocks and receive path
    d.pad.rxc = clk_level; // see RULE1
    // Receive and transmit clocks share the divider; the transmit side is unused in RMII
    d.pad.txc = clk_level; // see RULE9
    if (clk_tick)
    begin
      d.pad.rxdv = rx_i.valid;
      // Nibble forced to zero outside a frame so stale data never leaks out
      d.pad.rxd  = rx_i.valid ? rx_i.data : 4'h0; // see RULE11
      d.pad.rxer = rx_i.err & rx_i.valid;
    end
    d.pad.col = col_i;
    d.pad.crs = crs_i;

    // Link and activity indicator, active low
    if (!link_up_i)
    begin
      d.pad.link_activity_led = 1'h1; // see RULE12
    end
    else if (activity_i)
    begin
      if (blink_tick)
      begin
        d.pad.link_activity_led = ~q.pad.link_activity_led; // see RULE12
      end
    end
    else
    begin
      d.pad.link_activity_led = 1'h0; // see RULE12
    end

    // Reference clock watch, edges found by sampling the synchronised level
    d.ref_prev = pin_s.reference_clock_in;
    if (pin_s.reference_clock_in && !q.ref_prev)
    begin
      d.ref_cnt = '0;
    end
    else if (q.ref_cnt != REF_LOSS)
    begin
      d.ref_cnt = q.ref_cnt + 6'h01;
    end
    d.ref_alive = d.ref_cnt != REF_LOSS;

    // Events
    d.link_prev                  = link_up_i;
    ev[mpsl_pkg::IRQ_LINK]       = link_up_i != q.link_prev;
    ev[mpsl_pkg::IRQ_RXERR]      = rx_i.err & rx_i.valid;
    ev[mpsl_pkg::IRQ_COL]        = col_i;
    ev[mpsl_pkg::IRQ_REFLOSS]    = q.cfg.rmii & q.ref_alive & ~d.ref_alive;

    // Register writes
    if (req_i.we)
    begin
      case (req_i.addr)
        mpsl_pkg::REG_CTRL:
        begin
          d.cfg.speed100              = req_i.wdata[mpsl_pkg::CTRL_SPEED_BIT]; // see RULE8
          d.cfg.coding_loopback_strap = req_i.wdata[mpsl_pkg::CTRL_LOOP_BIT];
          d.cfg.isolate               = req_i.wdata[mpsl_pkg::CTRL_ISO_BIT];
        end
        mpsl_pkg::REG_VEND:
        begin
          d.intpol = req_i.wdata[mpsl_pkg::VEND_INTPOL_BIT]; // see RULE6
        end
        mpsl_pkg::REG_IRQ_STS:
        begin
          w1c = req_i.wdata[mpsl_pkg::IRQ_W-1:0];
        end
        mpsl_pkg::REG_IRQ_MSK:
        begin
          d.msk = req_i.wdata[mpsl_pkg::IRQ_W-1:0];
        end
        default:
        begin
          d.msk = q.msk;
        end
      endcase
    end
    // A new event beats a clear in the same cycle
    d.sts = (q.sts & ~w1c) | ev;

    // Register reads, data valid in the following cycle only
    if (req_i.re)
    begin
      case (req_i.addr)
        mpsl_pkg::REG_CTRL:
        begin
          d.rdata[mpsl_pkg::CTRL_SPEED_BIT] = q.cfg.speed100; // see RULE8
          d.rdata[mpsl_pkg::CTRL_LOOP_BIT]  = q.cfg.coding_loopback_strap;
          d.rdata[mpsl_pkg::CTRL_ISO_BIT]   = q.cfg.isolate;
        end
        mpsl_pkg::REG_VEND:
        begin
          d.rdata[mpsl_pkg::VEND_INTPOL_BIT] = q.intpol;
        end
        mpsl_pkg::REG_STRAP:
        begin
          d.rdata = {8'h00, q.ref_alive, q.strap};
        end
        mpsl_pkg::REG_IRQ_STS:
        begin
          d.rdata = {12'h000, q.sts};
        end
        mpsl_pkg::REG_IRQ_MSK:
        begin
          d.rdata = {12'h000, q.msk};
        end
        default:
        begin
          d.rdata = '0;
        end
      endcase
    end

    // Interrupt level and pin polarity
    d.irq      = |(q.sts & q.msk);
    d.pad.intr = q.intpol ? d.irq : ~d.irq; // see RULE6

    // Output enables follow the current configuration; isolate floats the MII side
    d.oe.rxd               = {4{~q.cfg.isolate}}; // see RULE3
    d.oe.rxdv              = ~q.cfg.isolate;
    d.oe.rxc               = ~q.cfg.isolate;
    d.oe.rxer              = ~q.cfg.isolate;
    d.oe.col               = ~q.cfg.isolate;
    d.oe.crs               = ~q.cfg.isolate;
    d.oe.txc               = ~q.cfg.isolate & ~q.cfg.rmii; // see RULE9
    d.oe.intr              = 1'h1; // see RULE13
    d.oe.link_activity_led = 1'h1;

    // Reset: every pin released to its strap resistor and the levels sampled
    if (!rstn_i)
    begin
      d                                  = '0;
      d.intpol                           = mpsl_pkg::INTPOL_RST;
      d.msk                              = mpsl_pkg::IRQ_MSK_RST;
      d.pad.link_activity_led            = 1'h1;
      d.strap.coding_loopback_strap      = pin_s.rxdv; // see RULE2
      d.strap.isolate                    = pin_s.rxer; // see RULE3
      d.strap.rmii                       = pin_s.col; // see RULE4
      d.strap.reduced_back_to_back_strap = pin_s.col & pin_s.crs; // see RULE5
      d.strap.phy_address_bit0_strap     = pin_s.intr; // see RULE7
      d.strap.speed100                   = pin_s.link_activity_led; // see RULE8
      // Shares the speed pin; a low level reads as both 10 Mbps and test
      d.strap.test_mode                  = ~pin_s.link_activity_led; // see RULE10
      d.cfg                              = d.strap; // see RULE13
    end
  end

  always_ff @(posedge mclk_i)
  begin
    q <= d;
  end

  assign pad_o    = q.pad;
  assign pad_oe_o = q.oe;
  assign rdata_o  = q.rdata;
  assign cfg_o    = q.cfg;
  assign irq_o    = q.irq;

  default clocking mpsl_cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  rxc_fast_a: assert property ($rose(pad_o.rxc) && cfg_o.speed100 && $stable(cfg_o.speed100) // see RULE1
    |-> ##1 pad_o.rxc ##1 !pad_o.rxc [*3] ##1 pad_o.rxc)
    else $error("receive clock period wrong at 100 Mbps");

  rxc_slow_a: assert property ($rose(pad_o.rxc) && !cfg_o.speed100 && $stable(cfg_o.speed100) // see RULE1
    |-> ##24 pad_o.rxc ##1 !pad_o.rxc)
    else $error("receive clock high time wrong at 10 Mbps");

  loop_strap_a: assert property ($rose(rstn_i) // see RULE2
    |-> q.strap.coding_loopback_strap == $past(pin_s.rxdv))
    else $error("loopback strap not taken from data valid pin");

  iso_strap_a: assert property ($rose(rstn_i) |-> q.strap.isolate == $past(pin_s.rxer) // see RULE3
    ##1 pad_oe_o.rxdv == !q.strap.isolate)
    else $error("isolate strap not taken or not applied");

  rmii_strap_a: assert property ($rose(rstn_i) // see RULE4
    |-> q.strap.rmii == $past(pin_s.col))
    else $error("reduced MII strap not taken from collision pin");

  btb_strap_a: assert property ($rose(rstn_i) // see RULE5
    |-> q.strap.reduced_back_to_back_strap == ($past(pin_s.col) && $past(pin_s.crs)))
    else $error("back-to-back strap wrong");

  int_level_a: assert property ($past(rstn_i) // see RULE6
    |-> pad_o.intr == ($past(|(q.sts & q.msk)) ~^ $past(q.intpol)))
    else $error("interrupt pin level or polarity wrong");

  addr_strap_a: assert property ($rose(rstn_i) // see RULE7
    |-> q.strap.phy_address_bit0_strap == $past(pin_s.intr))
    else $error("address bit 0 strap not taken from interrupt pin");

  speed_strap_a: assert property ($rose(rstn_i) // see RULE8
    |-> cfg_o.speed100 == $past(pin_s.link_activity_led))
    else $error("speed strap not taken from LED pin");

  txc_ref_a: assert property (cfg_o.rmii ##1 cfg_o.rmii |-> !pad_oe_o.txc) // see RULE9
    else $error("transmit clock pin driven in reference clock mode");

  rxd_idle_a: assert property (!pad_o.rxdv |-> pad_o.rxd == 4'h0) // see RULE11
    else $error("receive data not idle while data valid low");

  led_nolink_a: assert property ($past(rstn_i) && !$past(link_up_i) // see RULE12
    |-> pad_o.link_activity_led)
    else $error("LED not off without link");

  strap_hold_a: assert property ($past(rstn_i) |-> $stable(q.strap)) // see RULE13
    else $error("strap levels changed after reset");

  rmii_seen_c: cover property ($rose(rstn_i) && q.strap.rmii);
  led_blink_c: cover property (link_up_i && activity_i && $changed(pad_o.link_activity_led));
  irq_fire_c:  cover property ($rose(irq_o));
  ref_loss_c:  cover property ($rose(q.sts[mpsl_pkg::IRQ_REFLOSS]));

endmodule // mpsl_top

// file: mpsl_mac_model.sv
// Board straps and MAC side model resolving the shared pad levels
`timescale 1ns/10ps
module mpsl_mac_model (
  input  wire logic                [5:0] strap_i,
  input  wire logic                      ref_run_i,
  input  wire mpsl_pkg::mpsl_pad_t       pad_i,
  input  wire mpsl_pkg::mpsl_pad_t       pad_oe_i,
  output mpsl_pkg::mpsl_pin_in_t         pin_o
);
  logic reference_clock_in_q = 1'b0;

  // Reference stands still while stopped so loss can be seen
  always #80 if (ref_run_i) reference_clock_in_q = ~reference_clock_in_q;

  // An undriven pin falls to its board pull level
  always_comb
  begin
    pin_o.rxdv = pad_oe_i.rxdv ? pad_i.rxdv : strap_i[0];
    pin_o.rxer = pad_oe_i.rxer ? pad_i.rxer : strap_i[1];
    pin_o.col  = pad_oe_i.col  ? pad_i.col  : strap_i[2];
    pin_o.crs  = pad_oe_i.crs  ? pad_i.crs  : strap_i[3];
    pin_o.intr = pad_oe_i.intr ? pad_i.intr : strap_i[4];
    pin_o.link_activity_led = pad_oe_i.link_activity_led ?
                              pad_i.link_activity_led : strap_i[5];
    pin_o.reference_clock_in = pad_oe_i.txc ? pad_i.txc : reference_clock_in_q;
  end
endmodule // mpsl_mac_model

// file: testbench.sv
// Self-checking bench for the MII shared pin block
`timescale 1ns/10ps
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin err_total++; \
  $display("BAD %0t mismatch %h expected %h", $time, (act), (exp)); end end
module testbench;
  logic                   mclk_i = 1'b0;
  logic                   rstn_i = 1'b0;
  logic             [5:0] strap;
  logic                   ref_run = 1'b1;
  mpsl_pkg::mpsl_pin_in_t pin_i;
  mpsl_pkg::mpsl_pad_t    pad_o;
  mpsl_pkg::mpsl_pad_t    pad_oe_o;
  mpsl_pkg::mpsl_rx_t     rx_i = '0;
  logic                   col_i = 1'b0;
  logic                   crs_i = 1'b0;
  logic                   link_up_i = 1'b0;
  logic                   activity_i = 1'b0;
  mpsl_pkg::mpsl_req_t    req_i = '0;
  logic            [15:0] rdata_o;
  mpsl_pkg::mpsl_cfg_t    cfg_o;
  logic                   irq_o;
  int                     err_total = 0;
  int                     check_count = 0;
  int                     cyc = 0;
  int                     seed = 32'h4E7FAECC;
  logic             [5:0] tbl [4] = '{6'h2E, 6'h15, 6'h39, 6'h20};
  logic             [5:0] exq [$];

  always #4 mclk_i = ~mclk_i;

  mpsl_mac_model partner (.strap_i(strap), .ref_run_i(ref_run), .pad_i(pad_o),
                          .pad_oe_i(pad_oe_o), .pin_o(pin_i));

  mpsl_top #(.BLINK_CYC(8)) uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .pin_i(pin_i),
    .pad_o(pad_o), .pad_oe_o(pad_oe_o), .rx_i(rx_i), .col_i(col_i), .crs_i(crs_i),
    .link_up_i(link_up_i), .activity_i(activity_i), .req_i(req_i), .rdata_o(rdata_o),
    .cfg_o(cfg_o), .irq_o(irq_o));

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      print_verdict();
    end
  end

  task automatic wr(input logic [mpsl_pkg::AW-1:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    req_i <= '{addr:a, wdata:d, we:1'b1, re:1'b0};
    @(posedge mclk_i);
    req_i.we <= 1'b0;
  endtask

  task automatic rd(input logic [mpsl_pkg::AW-1:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    req_i <= '{addr:a, wdata:16'h0000, we:1'b0, re:1'b1};
    @(posedge mclk_i);
    req_i.re <= 1'b0;
    #1 d = rdata_o;
  endtask

  // Cycles up to the next rising edge of the receive clock pad
  task automatic rxc_rise(output int n);
    logic prev;
    n = 0;
    // Settled value, never the one launched in this time step
    #1 prev = pad_o.rxc;
    do
    begin
      @(posedge mclk_i);
      #1 n++;
      if (pad_o.rxc === 1'b1 && prev === 1'b0)
        break;
      prev = pad_o.rxc;
    end while (n < 200);
  endtask

  // Straps decode: test, addr0, speed, btb, rmii, isolate, loopback
  function automatic logic [6:0] exp_cfg(input logic [5:0] s);
    return {~s[5], s[4], s[5], s[2] & s[3], s[2], s[1], s[0]};
  endfunction

  initial
  begin
    logic [15:0] v;
    logic [31:0] r;
    logic [5:0]  e;
    logic        led;
    int          n;
    int          flips;
    strap = tbl[0];
    for (int i = 0; i < 4; i++)
    begin
      if (i > 0)
      begin
        // Test mode strap on entry 1 only, normal boards keep the pin high
        @(posedge mclk_i);
        strap <= tbl[i];
        rstn_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
      end
      else
        repeat (3) @(posedge mclk_i);
      #1 `CHK(pad_oe_o, 12'h000)
      @(posedge mclk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      #1 `CHK(cfg_o, exp_cfg(tbl[i]))
      `CHK(pad_oe_o.rxdv, ~tbl[i][1])
      `CHK(pad_oe_o.txc, ~(tbl[i][1] | tbl[i][2]))
      rd(mpsl_pkg::REG_STRAP, v);
      `CHK(v[6:0], exp_cfg(tbl[i]))
      rxc_rise(n);
      rxc_rise(n);
      `CHK(n, tbl[i][5] ? 5 : 50)
      if (tbl[i][2])
      begin
        ref_run <= 1'b0;
        repeat (60) @(posedge mclk_i);
        rd(mpsl_pkg::REG_IRQ_STS, v);
        `CHK(v[mpsl_pkg::IRQ_REFLOSS], 1'b1)
        ref_run <= 1'b1;
      end
    end
    repeat (6)
    begin
      r = $random(seed);
      @(posedge mclk_i);
      rx_i <= r[5:0];
      exq.push_back({r[5], r[5] & r[4], r[5] ? r[3:0] : 4'h0});
      rxc_rise(n);
      rxc_rise(n);
      e = exq.pop_front();
      `CHK({pad_o.rxdv, pad_o.rxer, pad_o.rxd}, e)
    end
    // Quiet receive input, or its error event would keep setting status
    @(posedge mclk_i);
    rx_i <= '0;
    wr(mpsl_pkg::REG_IRQ_MSK, 16'h0000);
    wr(mpsl_pkg::REG_IRQ_STS, 16'h000F);
    @(posedge mclk_i);
    col_i <= 1'b1;
    crs_i <= 1'b1;
    @(posedge mclk_i);
    col_i <= 1'b0;
    crs_i <= 1'b0;
    #1 `CHK({pad_o.col, pad_o.crs}, 2'b11)
    rd(mpsl_pkg::REG_IRQ_STS, v);
    `CHK(v[3:0], 4'h4)
    `CHK(irq_o, 1'b0)
    wr(mpsl_pkg::REG_IRQ_MSK, 16'h0004);
    repeat (2) @(posedge mclk_i);
    #1 `CHK({irq_o, pad_o.intr}, 2'b10)
    wr(mpsl_pkg::REG_VEND, 16'h0200);
    repeat (2) @(posedge mclk_i);
    #1 `CHK({irq_o, pad_o.intr}, 2'b11)
    wr(mpsl_pkg::REG_IRQ_STS, 16'h0004);
    repeat (2) @(posedge mclk_i);
    #1 `CHK({irq_o, pad_o.intr}, 2'b00)
    rd(5'h05, v);
    `CHK(v, 16'h0000)
    // LED is active low: dark without link
    repeat (3) @(posedge mclk_i);
    #1 `CHK(pad_o.link_activity_led, 1'b1)
    @(posedge mclk_i);
    link_up_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1 `CHK(pad_o.link_activity_led, 1'b0)
    @(posedge mclk_i);
    activity_i <= 1'b1;
    flips = 0;
    #1 led = pad_o.link_activity_led;
    repeat (40)
    begin
      @(posedge mclk_i);
      #1 if (pad_o.link_activity_led !== led) flips++;
      led = pad_o.link_activity_led;
    end
    `CHK(flips inside {[4:5]}, 1'b1)
    print_verdict();
  end
endmodule // testbench
